/* design/csee_cause_sel.sv */
// Overview of operation
// - stacked entries push pc then status; all but scall set mode 110, EM, GM; vector base or offset
// - misaligned fetch address vectors to offset 0x14
// - fetch missing every region with protection on vectors to 0x50
// - fetch breaking its region rights vectors to 0x18
// - breakpoint with debug mask clear saves status and pc to debug registers, 0x1C
// - debug mode runs debugger instructions; return-from-debug leaves it
// - unknown opcode or unacknowledged coprocessor instruction vectors to 0x20
// - simd, cache, java, tlb and unimplemented coprocessor instructions vector to 0x24
// - misaligned data read vectors to 0x34
// - misaligned data write vectors to 0x38
// - data read missing every region with protection on vectors to 0x60
// - data write missing every region with protection on vectors to 0x70
// - data read breaking region rights vectors to 0x3C
// - data write breaking region rights vectors to 0x40
// - miss and protection causes exist only when a protection unit is built in
// - privileged instruction in application mode vectors to 0x28
// - status flag set/clear is privileged only on the upper status half
// - with coprocessors, addressing an absent one vectors to 0x30
// - without coprocessors, every coprocessor instruction is unimplemented
// - scall in mode 000 or 001 stacks pc and status, sets mode 001, vectors 0x100
// - scall in other modes writes pc plus 2 to link register, vectors 0x100
// - return from scall resumes at the instruction after the scall
// - any request other than a breakpoint while the exception mask is set becomes unrecoverable, offset 0x00
`default_nettype none

package csee_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;
  // vector offsets
  localparam logic [31:0] VEC_UNRECOV   = 32'h00000000;
  localparam logic [31:0] VEC_FETCH_AL  = 32'h00000014;
  localparam logic [31:0] VEC_FETCH_PR  = 32'h00000018;
  localparam logic [31:0] VEC_BREAK     = 32'h0000001c;
  localparam logic [31:0] VEC_ILLEGAL   = 32'h00000020;
  localparam logic [31:0] VEC_UNIMPL    = 32'h00000024;
  localparam logic [31:0] VEC_PRIV      = 32'h00000028;
  localparam logic [31:0] VEC_COP_ABS   = 32'h00000030;
  localparam logic [31:0] VEC_RD_AL     = 32'h00000034;
  localparam logic [31:0] VEC_WR_AL     = 32'h00000038;
  localparam logic [31:0] VEC_RD_PR     = 32'h0000003c;
  localparam logic [31:0] VEC_WR_PR     = 32'h00000040;
  localparam logic [31:0] VEC_FETCH_MS  = 32'h00000050;
  localparam logic [31:0] VEC_RD_MS     = 32'h00000060;
  localparam logic [31:0] VEC_WR_MS     = 32'h00000070;
  localparam logic [31:0] VEC_SCALL     = 32'h00000100;
  // status word field positions
  localparam int unsigned SB_GM         = 16;
  localparam int unsigned SB_EM         = 21;
  localparam int unsigned SB_MODE_LO    = 22;
  localparam int unsigned SB_DM         = 26;
  localparam int unsigned SB_D          = 27;
  localparam int unsigned SR_UPPER_BIT  = 4;
  localparam logic [2:0]  MODE_APP      = 3'h0;
  localparam logic [2:0]  MODE_SUP      = 3'h1;
  localparam logic [2:0]  MODE_EXC      = 3'h6;
  localparam logic [31:0] SCALL_STEP    = 32'h00000002;
  localparam logic [31:0] STACK_STEP    = 32'h00000004;
  localparam logic [31:0] POP_STEP      = 32'h00000008;
  // register offsets
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_VBASE     = 8'h04;
  localparam logic [7:0]  REG_SSP       = 8'h08;
  localparam logic [7:0]  REG_DBG_RA    = 8'h0c;
  localparam logic [7:0]  REG_DBG_SS    = 8'h10;
  localparam logic [7:0]  REG_CFG       = 8'h14;
  // values after reset
  localparam logic [31:0] STATUS_RST    = 32'h00000000;
  localparam logic [31:0] WORD_RST      = 32'h00000000;

  typedef enum logic [4:0] {
    CZ_NONE, CZ_BREAK, CZ_FETCH_AL, CZ_FETCH_MS, CZ_FETCH_PR, CZ_ILLEGAL, CZ_UNIMPL,
    CZ_PRIV, CZ_COP_ABS, CZ_RD_AL, CZ_WR_AL, CZ_RD_MS, CZ_WR_MS, CZ_RD_PR, CZ_WR_PR,
    CZ_SCALL
  } csee_cause_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH_PC, ST_PUSH_SR} csee_fsm_t;
endpackage

module csee_cause_sel
  import csee_pkg::*;
#(
  parameter bit         MPU_PRESENT = 1'b1,
  parameter logic [7:0] COP_MASK    = 8'h00
)(
  input  wire logic        mpu_en,
  input  wire logic [2:0]  mode,
  input  wire logic        dbg_mask,
  input  wire logic        debug_break,
  input  wire logic        fetch_misaligned,
  input  wire logic        fetch_miss,
  input  wire logic        fetch_prot,
  input  wire logic        unknown_op,
  input  wire logic        unimpl_op,
  input  wire logic        cop_instr,
  input  wire logic [2:0]  cop_num,
  input  wire logic        cop_ack,
  input  wire logic        priv_instr,
  input  wire logic        sr_flag_instr,
  input  wire logic [4:0]  sr_flag_bit,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic        data_misaligned,
  input  wire logic        data_miss,
  input  wire logic        data_prot,
  input  wire logic        scall,
  output csee_cause_t      cause
);
  logic prot_on;
  logic priv_hit;
  logic cop_none;

  always_comb
  begin
    prot_on  = MPU_PRESENT && mpu_en;
    priv_hit = (mode == MODE_APP) &&
               (priv_instr || (sr_flag_instr && sr_flag_bit[SR_UPPER_BIT]));
    cop_none = (COP_MASK == 8'h00);
    cause    = CZ_NONE;
    // fetch side first, then decode, then data access, scall last
    if (debug_break && !dbg_mask)                      cause = CZ_BREAK;
    else if (fetch_misaligned)                         cause = CZ_FETCH_AL;
    else if (prot_on && fetch_miss)                    cause = CZ_FETCH_MS;
    else if (prot_on && fetch_prot)                    cause = CZ_FETCH_PR;
    else if (unknown_op)                               cause = CZ_ILLEGAL;
    else if (unimpl_op || (cop_instr && cop_none))     cause = CZ_UNIMPL;
    else if (priv_hit)                                 cause = CZ_PRIV;
    else if (cop_instr && !COP_MASK[cop_num])          cause = CZ_COP_ABS;
    else if (cop_instr && !cop_ack)                    cause = CZ_ILLEGAL;
    else if (data_rd && data_misaligned)               cause = CZ_RD_AL;
    else if (data_wr && data_misaligned)               cause = CZ_WR_AL;
    else if (prot_on && data_rd && data_miss)          cause = CZ_RD_MS;
    else if (prot_on && data_wr && data_miss)          cause = CZ_WR_MS;
    else if (prot_on && data_rd && data_prot)          cause = CZ_RD_PR;
    else if (prot_on && data_wr && data_prot)          cause = CZ_WR_PR;
    else if (scall)                                    cause = CZ_SCALL;
  end
endmodule

`default_nettype wire

/* design/csee_entry.sv */
`default_nettype none

module csee_entry
  import csee_pkg::*;
#(
  parameter bit         MPU_PRESENT = 1'b1,
  parameter logic [7:0] COP_MASK    = 8'h00
)(
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // register port
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata,
  // instruction under decision from the pipeline
  input  wire logic          req_valid,
  input  wire logic [DW-1:0] instr_pc,
  input  wire logic          debug_break,
  input  wire logic          fetch_misaligned,
  input  wire logic          fetch_miss,
  input  wire logic          fetch_prot,
  input  wire logic          unknown_op,
  input  wire logic          unimpl_op,
  input  wire logic          cop_instr,
  input  wire logic [2:0]    cop_num,
  input  wire logic          cop_ack,
  input  wire logic          priv_instr,
  input  wire logic          sr_flag_instr,
  input  wire logic [4:0]    sr_flag_bit,
  input  wire logic          data_rd,
  input  wire logic          data_wr,
  input  wire logic          data_misaligned,
  input  wire logic          data_miss,
  input  wire logic          data_prot,
  input  wire logic          scall,
  input  wire logic          ret_scall,
  input  wire logic          ret_debug,
  input  wire logic [DW-1:0] pop_pc,
  input  wire logic [DW-1:0] pop_status,
  input  wire logic [DW-1:0] link_value,
  // answers to the pipeline
  output logic               kill,
  output logic               busy,
  output logic               stack_we,
  output logic      [DW-1:0] stack_addr,
  output logic      [DW-1:0] stack_data,
  output logic               redirect,
  output logic      [DW-1:0] redirect_pc,
  output logic               link_we,
  output logic      [DW-1:0] link_data,
  output logic      [DW-1:0] status_word,
  output logic               debug_state
);
  typedef struct packed {
    csee_fsm_t   st;
    logic [31:0] status;
    logic [31:0] vbase;
    logic [31:0] ssp;
    logic [31:0] dbg_ra;
    logic [31:0] dbg_ss;
    logic        mpu_en;
    logic [31:0] rdata;
    logic        s_we;
    logic [31:0] s_addr;
    logic [31:0] s_data;
    logic        redir;
    logic [31:0] redir_pc;
    logic        l_we;
    logic [31:0] l_data;
    logic [31:0] lat_vec;
    logic [31:0] lat_old;
    logic [31:0] lat_new;
  } csee_regs_t;

  csee_regs_t  s_r;
  csee_regs_t  s_nxt;
  csee_cause_t cause;
  logic        take;
  logic        priv_ok;

  // -----------------------------------------------------------------
  // cause selection
  // -----------------------------------------------------------------
  csee_cause_sel #(
    .MPU_PRESENT (MPU_PRESENT),
    .COP_MASK    (COP_MASK)
  ) u_sel (
    .mpu_en           (s_r.mpu_en),
    .mode             (s_r.status[SB_MODE_LO+:3]),
    .dbg_mask         (s_r.status[SB_DM]),
    .debug_break      (debug_break),
    .fetch_misaligned (fetch_misaligned),
    .fetch_miss       (fetch_miss),
    .fetch_prot       (fetch_prot),
    .unknown_op       (unknown_op),
    .unimpl_op        (unimpl_op),
    .cop_instr        (cop_instr),
    .cop_num          (cop_num),
    .cop_ack          (cop_ack),
    .priv_instr       (priv_instr),
    .sr_flag_instr    (sr_flag_instr),
    .sr_flag_bit      (sr_flag_bit),
    .data_rd          (data_rd),
    .data_wr          (data_wr),
    .data_misaligned  (data_misaligned),
    .data_miss        (data_miss),
    .data_prot        (data_prot),
    .scall            (scall),
    .cause            (cause)
  );

  function automatic logic [31:0] vec_of(input csee_cause_t c);
    case (c)
      CZ_BREAK:    vec_of = VEC_BREAK;
      CZ_FETCH_AL: vec_of = VEC_FETCH_AL;
      CZ_FETCH_MS: vec_of = VEC_FETCH_MS;
      CZ_FETCH_PR: vec_of = VEC_FETCH_PR;
      CZ_ILLEGAL:  vec_of = VEC_ILLEGAL;
      CZ_UNIMPL:   vec_of = VEC_UNIMPL;
      CZ_PRIV:     vec_of = VEC_PRIV;
      CZ_COP_ABS:  vec_of = VEC_COP_ABS;
      CZ_RD_AL:    vec_of = VEC_RD_AL;
      CZ_WR_AL:    vec_of = VEC_WR_AL;
      CZ_RD_MS:    vec_of = VEC_RD_MS;
      CZ_WR_MS:    vec_of = VEC_WR_MS;
      CZ_RD_PR:    vec_of = VEC_RD_PR;
      CZ_WR_PR:    vec_of = VEC_WR_PR;
      CZ_SCALL:    vec_of = VEC_SCALL;
      default:     vec_of = VEC_UNRECOV;
    endcase
  endfunction

  // status after a full exception entry: mode 110 with both masks
  function automatic logic [31:0] exc_status(input logic [31:0] sr);
    logic [31:0] r;
    r                   = sr;
    r[SB_MODE_LO+:3]    = MODE_EXC;
    r[SB_EM]            = 1'b1;
    r[SB_GM]            = 1'b1;
    exc_status          = r;
  endfunction

  // -----------------------------------------------------------------
  // handshake towards the pipeline
  // -----------------------------------------------------------------
  // returns are themselves privileged; a refused one is dropped here, with no cause and no redirect
  assign priv_ok = (s_r.status[SB_MODE_LO+:3] != MODE_APP);
  assign take    = req_valid && (s_r.st == ST_IDLE) && (cause != CZ_NONE);
  // kill is combinational so the faulting instruction never writes back
  assign kill    = take;
  assign busy    = (s_r.st != ST_IDLE);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.s_we  = 1'b0;
    s_nxt.redir = 1'b0;
    s_nxt.l_we  = 1'b0;
    s_nxt.rdata = WORD_RST;

    // software access comes first so entry hardware overrides it in the same cycle
    if (reg_wr)
    begin
      case (reg_addr)
        REG_STATUS: s_nxt.status = reg_wdata;
        REG_VBASE:  s_nxt.vbase  = reg_wdata;
        REG_SSP:    s_nxt.ssp    = reg_wdata;
        REG_DBG_RA: s_nxt.dbg_ra = reg_wdata;
        REG_DBG_SS: s_nxt.dbg_ss = reg_wdata;
        REG_CFG:    s_nxt.mpu_en = reg_wdata[0];
        default:    ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        REG_STATUS: s_nxt.rdata = s_r.status;
        REG_VBASE:  s_nxt.rdata = s_r.vbase;
        REG_SSP:    s_nxt.rdata = s_r.ssp;
        REG_DBG_RA: s_nxt.rdata = s_r.dbg_ra;
        REG_DBG_SS: s_nxt.rdata = s_r.dbg_ss;
        REG_CFG:    s_nxt.rdata = {31'h0, s_r.mpu_en};
        default:    s_nxt.rdata = WORD_RST;
      endcase
    end

    case (s_r.st)
      ST_IDLE:
      begin
        if (take && (cause == CZ_BREAK))
        begin
          // debug entry never touches the stack
          s_nxt.dbg_ss        = s_r.status;
          s_nxt.dbg_ra        = instr_pc;
          s_nxt.status        = exc_status(s_r.status);
          s_nxt.status[SB_D]  = 1'b1;
          s_nxt.status[SB_DM] = 1'b1;
          s_nxt.redir         = 1'b1;
          s_nxt.redir_pc      = s_r.vbase | VEC_BREAK;
        end
        else if (take && (cause == CZ_SCALL) && !s_r.status[SB_EM] &&
                 (s_r.status[SB_MODE_LO+2:SB_MODE_LO+1] != 2'b00))
        begin
          s_nxt.l_we     = 1'b1;
          s_nxt.l_data   = instr_pc + SCALL_STEP;
          s_nxt.redir    = 1'b1;
          s_nxt.redir_pc = s_r.vbase | VEC_SCALL;
        end
        else if (take)
        begin
          s_nxt.lat_old = s_r.status;
          if (s_r.status[SB_EM])
          begin
            s_nxt.lat_vec = VEC_UNRECOV;
            s_nxt.lat_new = exc_status(s_r.status);
          end
          else if (cause == CZ_SCALL)
          begin
            s_nxt.lat_vec                  = VEC_SCALL;
            s_nxt.lat_new                  = s_r.status;
            s_nxt.lat_new[SB_MODE_LO+:3]   = MODE_SUP;
          end
          else
          begin
            s_nxt.lat_vec = vec_of(cause);
            s_nxt.lat_new = exc_status(s_r.status);
          end
          // first push: return address, pre-decremented
          s_nxt.s_we   = 1'b1;
          s_nxt.s_addr = s_r.ssp - STACK_STEP;
          s_nxt.s_data = instr_pc;
          s_nxt.ssp    = s_r.ssp - STACK_STEP;
          s_nxt.st     = ST_PUSH_PC;
        end
        else if (req_valid && ret_debug && priv_ok && s_r.status[SB_D])
        begin
          s_nxt.status   = s_r.dbg_ss;
          s_nxt.redir    = 1'b1;
          s_nxt.redir_pc = s_r.dbg_ra;
        end
        else if (req_valid && ret_scall && priv_ok)
        begin
          s_nxt.redir = 1'b1;
          if (s_r.status[SB_MODE_LO+:3] == MODE_SUP)
          begin
            s_nxt.redir_pc = pop_pc + SCALL_STEP;
            s_nxt.status   = pop_status;
            s_nxt.ssp      = s_r.ssp + POP_STEP;
          end
          else
          begin
            s_nxt.redir_pc = link_value;
          end
        end
      end
      ST_PUSH_PC:
      begin
        s_nxt.s_we     = 1'b1;
        s_nxt.s_addr   = s_r.ssp - STACK_STEP;
        s_nxt.s_data   = s_r.lat_old;
        s_nxt.ssp      = s_r.ssp - STACK_STEP;
        s_nxt.status   = s_r.lat_new;
        s_nxt.redir    = 1'b1;
        s_nxt.redir_pc = s_r.vbase | s_r.lat_vec;
        s_nxt.st       = ST_PUSH_SR;
      end
      ST_PUSH_SR:
      begin
        // one settling cycle so the handler fetch sees the new status
        s_nxt.st = ST_IDLE;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.status   <= STATUS_RST;
      s_r.vbase    <= WORD_RST;
      s_r.ssp      <= WORD_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata   = s_r.rdata;
  assign stack_we    = s_r.s_we;
  assign stack_addr  = s_r.s_addr;
  assign stack_data  = s_r.s_data;
  assign redirect    = s_r.redir;
  assign redirect_pc = s_r.redir_pc;
  assign link_we     = s_r.l_we;
  assign link_data   = s_r.l_data;
  assign status_word = s_r.status;
  assign debug_state = s_r.status[SB_D];
endmodule

`default_nettype wire

/* tb/csee_pipe_model.sv */
`default_nettype none

module csee_pipe_model
  import csee_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  input  wire logic          stack_we,
  input  wire logic [DW-1:0] stack_data,
  input  wire logic          link_we,
  input  wire logic [DW-1:0] link_data,
  output var  logic [DW-1:0] pop_pc,
  output var  logic [DW-1:0] pop_status,
  output var  logic [DW-1:0] link_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // two-word stack top only: enough for one return, deeper nesting is not modelled
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pop_pc     <= 32'h0;
      pop_status <= 32'h0;
      link_value <= 32'h0;
    end
    else
    begin
      if (stack_we)
      begin
        pop_pc     <= pop_status;
        pop_status <= stack_data;
      end
      if (link_we)
        link_value <= link_data;
    end
  end
endmodule

`default_nettype wire

/* tb/csee_entry_checker.sv */
`default_nettype none

module csee_entry_checker
  import csee_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst_b,
  input wire logic [DW-1:0] instr_pc,
  input wire logic          debug_break,
  input wire logic          priv_instr,
  input wire logic          scall,
  input wire logic          kill,
  input wire logic          busy,
  input wire logic          stack_we,
  input wire logic [DW-1:0] stack_addr,
  input wire logic [DW-1:0] stack_data,
  input wire logic          redirect,
  input wire logic [DW-1:0] redirect_pc,
  input wire logic          link_we,
  input wire logic [DW-1:0] link_data,
  input wire logic [DW-1:0] status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic brk;
  logic lnk;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  assign brk = debug_break && !status_word[SB_DM];
  // offsets are checked on the low bits: vector base is kept 4 KiB aligned
  assign lnk = scall && status_word[24:23] != 2'h0 && !status_word[SB_EM];

  a_push_pc: assert property (kill && !brk && !lnk |=>
    stack_we && stack_data == $past(instr_pc))
    else $error("first push is not the pc");
  a_push_order: assert property (stack_we && !$past(stack_we) |=>
    stack_we && stack_addr == $past(stack_addr) - STACK_STEP)
    else $error("second push not one word below");
  // stacking holds busy for the two push cycles only
  a_busy_len: assert property (kill && !brk && !lnk |=> busy [*2] ##1 !busy)
    else $error("stacking length wrong");
  a_exc_status: assert property (kill && !brk && !scall |-> ##2 redirect &&
    status_word[24:22] == MODE_EXC && status_word[SB_EM] && status_word[SB_GM])
    else $error("entry status wrong");
  a_unrecov_vec: assert property (kill && !brk && status_word[SB_EM] |->
    ##2 redirect_pc[8:0] == 9'h000)
    else $error("masked request not unrecoverable");
  a_break_entry: assert property (kill && brk |=> redirect && !stack_we &&
    redirect_pc[8:0] == VEC_BREAK[8:0] && status_word[SB_D] && status_word[SB_DM])
    else $error("breakpoint entry wrong");
  a_scall_link: assert property (kill && lnk |=> link_we && !busy &&
    link_data == $past(instr_pc) + SCALL_STEP && status_word == $past(status_word))
    else $error("scall link entry wrong");
  a_priv_vec: assert property (kill && priv_instr && !brk && !status_word[SB_EM] &&
    status_word[24:22] == MODE_APP |-> ##2 redirect_pc[8:0] == VEC_PRIV[8:0])
    else $error("privilege vector wrong");
  a_stack_busy: assert property (stack_we |-> busy)
    else $error("push outside stacking");
  a_no_take_busy: assert property (busy |-> !kill)
    else $error("take while stacking");
endmodule

bind csee_entry csee_entry_checker csee_entry_checker_i (.core_clk, .rst_b, .instr_pc,
  .debug_break, .priv_instr, .scall, .kill, .busy, .stack_we, .stack_addr, .stack_data,
  .redirect, .redirect_pc, .link_we, .link_data, .status_word);

`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none

module tb_top
  import csee_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk, rst_b, reg_wr, reg_rd, req_valid, kill, busy, stack_we, redirect;
  logic          link_we, debug_state, debug_break, fetch_misaligned, fetch_miss, fetch_prot;
  logic          unknown_op, unimpl_op, cop_instr, cop_ack, priv_instr, sr_flag_instr, ret_debug;
  logic          data_rd, data_wr, data_misaligned, data_miss, data_prot, scall, ret_scall;
  logic [2:0]    cop_num;
  logic [4:0]    sr_flag_bit;
  logic [17:0]   flg;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, instr_pc, stack_addr, stack_data, redirect_pc, link_data;
  logic [DW-1:0] status_word, pop_pc, pop_status, link_value, sp, vb, st, pc, rp, lk, old;
  logic [DW-1:0] sq[$];
  int            mismatches, compares, i;
  int            seed = 32'h0237d57a;
  logic [17:0]   tf[15] = '{18'h2, 18'h4, 18'h8, 18'h10, 18'h20, 18'h40, 18'h40, 18'h100,
    18'h200, 18'h1400, 18'h1800, 18'h2400, 18'h2800, 18'h4400, 18'h4800};
  logic [DW-1:0] tv[15] = '{VEC_FETCH_AL, VEC_FETCH_MS, VEC_FETCH_PR, VEC_ILLEGAL, VEC_UNIMPL,
    VEC_COP_ABS, VEC_ILLEGAL, VEC_PRIV, VEC_PRIV, VEC_RD_AL, VEC_WR_AL, VEC_RD_MS, VEC_WR_MS,
    VEC_RD_PR, VEC_WR_PR};
  assign {ret_debug, ret_scall, scall, data_prot, data_miss, data_misaligned, data_wr, data_rd,
    sr_flag_instr, priv_instr, cop_ack, cop_instr, unimpl_op, unknown_op, fetch_prot,
    fetch_miss, fetch_misaligned, debug_break} = flg;

  csee_entry #(.MPU_PRESENT(1'b1), .COP_MASK(8'h01)) csee_entry_i (.core_clk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .instr_pc, .debug_break,
    .fetch_misaligned, .fetch_miss, .fetch_prot, .unknown_op, .unimpl_op, .cop_instr, .cop_num,
    .cop_ack, .priv_instr, .sr_flag_instr, .sr_flag_bit, .data_rd, .data_wr, .data_misaligned,
    .data_miss, .data_prot, .scall, .ret_scall, .ret_debug, .pop_pc, .pop_status, .link_value,
    .kill, .busy, .stack_we, .stack_addr, .stack_data, .redirect, .redirect_pc, .link_we,
    .link_data, .status_word, .debug_state);
  csee_pipe_model csee_pipe_model_i (.core_clk, .rst_b, .stack_we, .stack_data, .link_we,
    .link_data, .pop_pc, .pop_status, .link_value);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(negedge core_clk)
  begin
    if (stack_we)
      sq.push_back(stack_data);
    if (redirect)
      rp = redirect_pc;
    if (link_we)
      lk = link_data;
  end

  // ----------------------------
  // bus, request and check tasks
  // ----------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // one instruction per call; the stacking window is waited out before returning
  task automatic go(input logic [17:0] f, input logic [4:0] sb, input logic [2:0] cn,
                    input logic k);
    sq.delete();
    pc = $random(seed) & 32'hffff_fffe;
    @(posedge core_clk);
    flg <= f;
    sr_flag_bit <= sb;
    cop_num <= cn;
    instr_pc <= pc;
    req_valid <= 1'b1;
    #1;
    chk({31'h0, kill}, {31'h0, k});
    @(posedge core_clk);
    req_valid <= 1'b0;
    flg <= 18'h0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic ent(input logic [17:0] f, input logic [4:0] sb, input logic [2:0] cn,
                     input logic [31:0] off, input logic [2:0] m);
    old = st;
    go(f, sb, cn, 1'b1);
    sp = sp - POP_STEP;
    st[24:22] = m;
    if (m == MODE_EXC)
      st = st | 32'h0021_0000;
    chk(sq[0], pc);
    chk(sq[1], old);
    chk(rp, vb | off);
    chk(stack_addr, sp);
    rd(REG_STATUS, st);
    rd(REG_SSP, sp);
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    {rst_b, reg_wr, reg_rd, req_valid, flg, cop_num, sr_flag_bit} = '0;
    {reg_addr, reg_wdata, instr_pc} = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    vb = $random(seed) & 32'hffff_f000;
    sp = 32'h0000_8000;
    rd(REG_STATUS, STATUS_RST);
    rd(8'h18, WORD_RST);
    wr(REG_VBASE, vb);
    wr(REG_SSP, sp);
    wr(REG_CFG, 32'h1);
    rd(REG_VBASE, vb);
    $display("test registers done");
    for (i = 0; i < 15; i++)
    begin
      st = 32'h0;
      wr(REG_STATUS, st);
      ent(tf[i], {1'b1, 4'($random(seed))}, (i == 5) ? 3'h3 : 3'h0, tv[i], MODE_EXC);
    end
    wr(REG_STATUS, 32'h0);
    go(18'h200, 5'h03, 3'h0, 1'b0);
    go(18'h0c0, 5'h00, 3'h0, 1'b0);
    wr(REG_CFG, 32'h0);
    go(18'h2404, 5'h00, 3'h0, 1'b0);
    wr(REG_CFG, 32'h1);
    $display("test causes done");
    st = 32'h01a1_0000;
    wr(REG_STATUS, st);
    ent(18'h10, 5'h00, 3'h0, VEC_UNRECOV, MODE_EXC);
    st = 32'h0;
    wr(REG_STATUS, st);
    ent(18'h8000, 5'h00, 3'h0, VEC_SCALL, MODE_SUP);
    old = pc;
    go(18'h10000, 5'h00, 3'h0, 1'b0);
    chk(rp, old + SCALL_STEP);
    sp = sp + POP_STEP;
    rd(REG_STATUS, 32'h0);
    rd(REG_SSP, sp);
    st = 32'h0180_0005;
    wr(REG_STATUS, st);
    go(18'h8000, 5'h00, 3'h0, 1'b1);
    chk(lk, pc + SCALL_STEP);
    chk(rp, vb | VEC_SCALL);
    rd(REG_STATUS, st);
    rd(REG_SSP, sp);
    $display("test scall done");
    go(18'h1, 5'h00, 3'h0, 1'b1);
    old = pc;
    chk(rp, vb | VEC_BREAK);
    rd(REG_DBG_SS, st);
    rd(REG_DBG_RA, old);
    rd(REG_STATUS, st | 32'h0c21_0000);
    chk({31'h0, debug_state}, 32'h1);
    go(18'h20000, 5'h00, 3'h0, 1'b0);
    chk(rp, old);
    chk({31'h0, debug_state}, 32'h0);
    rd(REG_STATUS, st);
    $display("test debug done");
    end_sim();
  end
endmodule

`default_nettype wire
